// ===== inc/scc_pkg.sv
// Notes on behaviour
// - temperature setup word is copied into use at every measurement start.
// - temperature setup bits 2:0 pick the reference capacitor, default 010.
// - temperature setup bits 5:3 pick the offset capacitor, default 010.
// - temperature setup bits 8:6 hold the temperature trim, default 110.
// - bits 11:10 pick resolution and conversion time, 0.7ms up to 18.5ms.
// - customer word is taken into use at reset and on leaving command mode.
// - customer bits 8:7 set low alarm polarity and open-drain drive.
// - customer bits 10:9 set high alarm polarity and open-drain drive.
// - customer bit 11 picks the serial clock edge for sampling MISO.
// - customer bit 13 is sampled for the command window only just after reset, while still 0, so the window is always 10ms.
// - correction is either two-region quadratic or single-region cubic.
// - raw value is offset, drift corrected, then divided by drift gain term.
// - region inputs are min of value and split, max of zero and excess; in cubic mode region one takes the whole value.
// - two-region output sums quadratic plus linear terms with own coefficients.
// - cubic mode output is cubic, quadratic and linear terms of gained value.
// - the offset coefficient is the correction referred to half full scale.
// - temperature delta is raw temperature minus the stored reference.
// - cubic mode reuses the region-two quadratic slot as cubic coefficient.
package scc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ADDR_W  = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [7:0] IDX_TEMP_SETUP = 8'h11;
  localparam logic [7:0] IDX_CUST_SETUP = 8'h1C;
  localparam logic [7:0] IDX_COEF_BASE  = 8'h20;
  localparam logic [7:0] IDX_MODE       = 8'h2B;
  localparam logic [7:0] IDX_STATUS     = 8'h2C;
  localparam logic [7:0] IDX_RESULT     = 8'h2D;
  localparam logic [7:0] IDX_TEMP_CORRECTED_RAW      = 8'h2E;
  localparam int NUM_COEF = 11;
  localparam logic [7:0] NUM_COEF_B = 8'h0B;
  localparam int CI_OFFSET = 0;
  localparam int CI_ZERO_DRIFT = 1;
  localparam int CI_ZERO_DRIFT_SQ = 2;
  localparam int CI_SPAN_DRIFT = 3;
  localparam int CI_SPAN_DRIFT_SQ = 4;
  localparam int CI_TEMP_REF = 5;
  localparam int CI_SPLIT = 6;
  localparam int CI_GAIN_ONE = 7;
  localparam int CI_SQ_ONE = 8;
  localparam int CI_GAIN_TWO = 9;
  localparam int CI_SQ_TWO = 10;
  localparam int ST_BIT_BUSY = 0;
  localparam int ST_BIT_TBUSY = 1;
  localparam int ST_BIT_WIN = 2;
  localparam int MODE_BIT_CUBIC = 0;
  localparam logic [15:0] TEMP_SETUP_RST = 16'h8D92;
  localparam logic [15:0] CUST_SETUP_RST = 16'h0028;
  localparam logic [15:0] COEF_RST = 16'h0000;
  localparam int CONV_US_8 = 700;
  localparam int CONV_US_10 = 1600;
  localparam int CONV_US_12 = 5000;
  localparam int CONV_US_14 = 18500;
  localparam int CMD_WIN_US_LONG = 10000;
  localparam int CMD_WIN_US_SHORT = 3000;
  localparam int CONV_CYC_8 = CONV_US_8 * CLK_MHZ;
  localparam int CONV_CYC_10 = CONV_US_10 * CLK_MHZ;
  localparam int CONV_CYC_12 = CONV_US_12 * CLK_MHZ;
  localparam int CONV_CYC_14 = CONV_US_14 * CLK_MHZ;
  localparam int WIN_CYC_LONG = CMD_WIN_US_LONG * CLK_MHZ;
  localparam int WIN_CYC_SHORT = CMD_WIN_US_SHORT * CLK_MHZ;
  localparam int TIMER_W = 21;
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam int DP_W = 48;
  localparam int DRIFT_FRAC = 15;
  localparam int GAIN_FRAC = 13;
  localparam int SQ_FRAC = 16;
  localparam int POLY_FRAC = 15;
  localparam logic signed [47:0] DP_UNITY = 48'sh8000;
  localparam logic signed [47:0] DP_ONE = 48'sh1;
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [1:0] resolution;
    logic       rsvd9;
    logic [2:0] temp_trim;
    logic [2:0] zero_cap_select;
    logic [2:0] reference_cap_select;
  } scc_tcfg_s;
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       fast_startup;
    logic       ready_open_drain;
    logic       spi_sample_falling;
    logic       alarm_high_od;
    logic       alarm_high_pol;
    logic       alarm_low_od;
    logic       alarm_low_pol;
    logic [6:0] slave_address_field;
  } scc_ccfg_s;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_NUM  = 4'b0010,
    ST_DIV  = 4'b0100,
    ST_POLY = 4'b1000
  } scc_state_e;
endpackage

// ===== design/scc_sensor_config_and_correction.sv
module scc_sensor_config_and_correction #(
  parameter int unsigned CONV_CYC_8_P    = scc_pkg::CONV_CYC_8,
  parameter int unsigned CONV_CYC_10_P   = scc_pkg::CONV_CYC_10,
  parameter int unsigned CONV_CYC_12_P   = scc_pkg::CONV_CYC_12,
  parameter int unsigned CONV_CYC_14_P   = scc_pkg::CONV_CYC_14,
  parameter int unsigned WIN_CYC_LONG_P  = scc_pkg::WIN_CYC_LONG,
  parameter int unsigned WIN_CYC_SHORT_P = scc_pkg::WIN_CYC_SHORT
) (
  input  wire logic                        REF_CLK,
  input  wire logic                        ARST_N,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [scc_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  input  wire logic                        MEAS_START,
  input  wire logic [15:0]                 RAW_CAP,
  input  wire logic [15:0]                 RAW_TEMP,
  input  wire logic                        LEAVE_CMD,
  input  wire logic                        ALARM_LOW_REQ,
  input  wire logic                        ALARM_HIGH_REQ,
  output scc_pkg::scc_tcfg_s               TEMP_CFG,
  output logic                             TEMP_BUSY,
  output logic      [6:0]                  SLAVE_ADDR,
  output logic                             SPI_SAMPLE_FALLING,
  output logic                             READY_OPEN_DRAIN,
  output logic                             CMD_WINDOW_OPEN,
  output logic                             ALM_LOW_O,
  output logic                             ALM_LOW_OE_N,
  output logic                             ALM_HIGH_O,
  output logic                             ALM_HIGH_OE_N,
  output logic      [31:0]                 CORR_OUT,
  output logic                             CORR_VALID
);
  import scc_pkg::*;

  localparam logic [TIMER_W-1:0] T8  = TIMER_W'(CONV_CYC_8_P);
  localparam logic [TIMER_W-1:0] T10 = TIMER_W'(CONV_CYC_10_P);
  localparam logic [TIMER_W-1:0] T12 = TIMER_W'(CONV_CYC_12_P);
  localparam logic [TIMER_W-1:0] T14 = TIMER_W'(CONV_CYC_14_P);
  localparam logic [TIMER_W-1:0] WL  = TIMER_W'(WIN_CYC_LONG_P);
  localparam logic [TIMER_W-1:0] WS  = TIMER_W'(WIN_CYC_SHORT_P);

  function automatic logic signed [DP_W-1:0] sx(input logic [15:0] v);
    return {{(DP_W-16){v[15]}}, v};
  endfunction

  function automatic logic [TIMER_W-1:0] conv_len(input logic [1:0] res);
    if (res == RES_8) return T8;
    else if (res == RES_10) return T10;
    else if (res == RES_12) return T12;
    else return T14;
  endfunction

  // register file and apb slave
  scc_tcfg_s   temp_word, next_temp_word;
  scc_ccfg_s   cust_word, next_cust_word;
  logic [15:0] coef [NUM_COEF];
  logic [15:0] next_coef [NUM_COEF];
  logic        cubic_mode, next_cubic_mode;
  logic [31:0] prdata, next_prdata;
  logic        pready, next_pready;
  logic        pslverr, next_pslverr;
  scc_state_e  state, next_state;
  logic [31:0] corr, next_corr;
  logic signed [DP_W-1:0] temp_corrected_raw, next_temp_corrected_raw;
  logic        temp_busy, win_open;

  always_comb begin
    logic [7:0]  idx;
    logic [3:0]  ci;
    logic        ok;
    logic        is_coef;
    logic [31:0] rd;
    logic [31:0] st;
    idx = PADDR[IDX_MSB:IDX_LSB];
    ci = 4'(idx - IDX_COEF_BASE);
    is_coef = (idx >= IDX_COEF_BASE) && (idx < IDX_COEF_BASE + NUM_COEF_B);
    st = 32'h0;
    st[ST_BIT_BUSY] = (state != ST_IDLE);
    st[ST_BIT_TBUSY] = temp_busy;
    st[ST_BIT_WIN] = win_open;
    ok = (PADDR[ADDR_W-1:IDX_MSB+1] == '0);
    rd = 32'h0;
    if (idx == IDX_TEMP_SETUP) begin
      rd = {16'h0, temp_word};
    end else if (idx == IDX_CUST_SETUP) begin
      rd = {16'h0, cust_word};
    end else if (is_coef) begin
      rd = {16'h0, coef[ci]};
    end else if (idx == IDX_MODE) begin
      rd = {31'h0, cubic_mode};
    end else if (idx == IDX_STATUS) begin
      rd = st;
    end else if (idx == IDX_RESULT) begin
      rd = corr;
    end else if (idx == IDX_TEMP_CORRECTED_RAW) begin
      rd = temp_corrected_raw[31:0];
    end else begin
      ok = 1'b0;
    end
    next_temp_word = temp_word;
    next_cust_word = cust_word;
    next_coef = coef;
    next_cubic_mode = cubic_mode;
    next_pready = PSEL && !PENABLE;
    next_pslverr = PSEL && !PENABLE && !ok;
    next_prdata = prdata;
    if (PSEL && !PENABLE) begin
      next_prdata = (ok && !PWRITE) ? rd : 32'h0;
    end
    if (PSEL && PENABLE && PWRITE && pready && !pslverr) begin
      if (idx == IDX_TEMP_SETUP) begin
        next_temp_word = PWDATA[15:0];
      end else if (idx == IDX_CUST_SETUP) begin
        next_cust_word = PWDATA[15:0];
      end else if (is_coef) begin
        next_coef[ci] = PWDATA[15:0];
      end else if (idx == IDX_MODE) begin
        next_cubic_mode = PWDATA[MODE_BIT_CUBIC];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      temp_word <= TEMP_SETUP_RST;
      cust_word <= CUST_SETUP_RST;
      for (int i = 0; i < NUM_COEF; i++) begin
        coef[i] <= COEF_RST;
      end
      cubic_mode <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      temp_word <= next_temp_word;
      cust_word <= next_cust_word;
      coef <= next_coef;
      cubic_mode <= next_cubic_mode;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign PRDATA = prdata;
  assign PREADY = pready;
  assign PSLVERR = pslverr;

  // active configuration, conversion timer and command window
  scc_tcfg_s          tcfg, next_tcfg;
  scc_ccfg_s          ccfg, next_ccfg;
  logic               load_pend, next_load_pend;
  logic [TIMER_W-1:0] conv_cnt, next_conv_cnt;
  logic [TIMER_W-1:0] win_cnt, next_win_cnt;
  logic               next_temp_busy, next_win_open;
  logic               start_ok;

  assign start_ok = MEAS_START && (state == ST_IDLE);

  always_comb begin
    next_tcfg = tcfg;
    next_conv_cnt = (conv_cnt != '0) ? conv_cnt - 1'b1 : conv_cnt;
    if (start_ok) begin
      next_tcfg = temp_word;
      next_conv_cnt = conv_len(temp_word.resolution);
    end
    next_temp_busy = (next_conv_cnt != '0);
    next_load_pend = 1'b0;
    next_ccfg = ccfg;
    if (load_pend || LEAVE_CMD) begin
      next_ccfg = cust_word;
    end
    next_win_cnt = (win_cnt != '0) ? win_cnt - 1'b1 : win_cnt;
    if (load_pend) begin
      next_win_cnt = cust_word.fast_startup ? WS : WL;
    end else if (LEAVE_CMD) begin
      next_win_cnt = '0;
    end
    next_win_open = (next_win_cnt != '0);
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tcfg <= TEMP_SETUP_RST;
      ccfg <= CUST_SETUP_RST;
      load_pend <= 1'b1;
      conv_cnt <= '0;
      win_cnt <= '0;
      temp_busy <= 1'b0;
      win_open <= 1'b0;
    end else begin
      tcfg <= next_tcfg;
      ccfg <= next_ccfg;
      load_pend <= next_load_pend;
      conv_cnt <= next_conv_cnt;
      win_cnt <= next_win_cnt;
      temp_busy <= next_temp_busy;
      win_open <= next_win_open;
    end
  end

  assign TEMP_CFG = tcfg;
  assign TEMP_BUSY = temp_busy;
  assign SLAVE_ADDR = ccfg.slave_address_field;
  assign SPI_SAMPLE_FALLING = ccfg.spi_sample_falling;
  assign READY_OPEN_DRAIN = ccfg.ready_open_drain;
  assign CMD_WINDOW_OPEN = win_open;

  // correction datapath
  logic signed [DP_W-1:0] raw_c, next_raw_c;
  logic signed [DP_W-1:0] dt, next_dt;
  logic signed [DP_W-1:0] num, next_num;
  logic signed [DP_W-1:0] den, next_den;
  logic signed [DP_W-1:0] r1, r2;
  logic                   valid, next_valid;

  always_comb begin
    logic signed [DP_W-1:0] split;
    logic signed [DP_W-1:0] g1;
    logic signed [DP_W-1:0] g2;
    logic signed [DP_W-1:0] sq1;
    logic signed [DP_W-1:0] sq2;
    logic signed [DP_W-1:0] cb1;
    logic signed [DP_W-1:0] acc;
    split = sx(coef[CI_SPLIT]);
    next_state = state;
    next_raw_c = raw_c;
    next_dt = dt;
    next_num = num;
    next_den = den;
    next_temp_corrected_raw = temp_corrected_raw;
    next_corr = corr;
    next_valid = 1'b0;
    r1 = (cubic_mode || temp_corrected_raw < split) ? temp_corrected_raw : split;
    r2 = (temp_corrected_raw > split) ? temp_corrected_raw - split : '0;
    g1 = (sx(coef[CI_GAIN_ONE]) * r1) >>> GAIN_FRAC;
    g2 = (sx(coef[CI_GAIN_TWO]) * r2) >>> GAIN_FRAC;
    sq1 = (g1 * g1) >>> SQ_FRAC;
    sq2 = (g2 * g2) >>> SQ_FRAC;
    cb1 = (sq1 * g1) >>> SQ_FRAC;
    acc = ((sx(coef[CI_SQ_ONE]) * sq1) >>> POLY_FRAC) + g1;
    case (state)
      ST_IDLE: begin
        if (MEAS_START) begin
          next_raw_c = {{(DP_W-16){1'b0}}, RAW_CAP};
          next_dt = sx(RAW_TEMP) - sx(coef[CI_TEMP_REF]);
          next_state = ST_NUM;
        end
      end
      ST_NUM: begin
        next_num = raw_c + sx(coef[CI_OFFSET]) + ((dt * (sx(coef[CI_ZERO_DRIFT])
                   + ((dt * sx(coef[CI_ZERO_DRIFT_SQ])) >>> DRIFT_FRAC))) >>> DRIFT_FRAC);
        next_den = DP_UNITY + ((dt * (sx(coef[CI_SPAN_DRIFT])
                   + ((dt * sx(coef[CI_SPAN_DRIFT_SQ])) >>> DRIFT_FRAC))) >>> DRIFT_FRAC);
        next_state = ST_DIV;
      end
      ST_DIV: begin
        next_temp_corrected_raw = (num <<< DRIFT_FRAC) / ((den > 0) ? den : DP_ONE);
        next_state = ST_POLY;
      end
      ST_POLY: begin
        if (cubic_mode) begin
          acc = acc + ((sx(coef[CI_SQ_TWO]) * cb1) >>> POLY_FRAC);
        end else begin
          acc = acc + ((sx(coef[CI_SQ_TWO]) * sq2) >>> POLY_FRAC) + g2;
        end
        next_corr = acc[31:0];
        next_valid = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_IDLE;
      raw_c <= '0;
      dt <= '0;
      num <= '0;
      den <= DP_UNITY;
      temp_corrected_raw <= '0;
      corr <= 32'h0;
      valid <= 1'b0;
    end else begin
      state <= next_state;
      raw_c <= next_raw_c;
      dt <= next_dt;
      num <= next_num;
      den <= next_den;
      temp_corrected_raw <= next_temp_corrected_raw;
      corr <= next_corr;
      valid <= next_valid;
    end
  end

  assign CORR_OUT = corr;
  assign CORR_VALID = valid;

  // alarm pins, enable low while driving
  logic al_o, al_oe_n, ah_o, ah_oe_n;
  logic next_al_o, next_al_oe_n, next_ah_o, next_ah_oe_n;

  always_comb begin
    logic lvl_l;
    logic lvl_h;
    lvl_l = ALARM_LOW_REQ ^ ccfg.alarm_low_pol;
    next_al_o = ccfg.alarm_low_od ? 1'b0 : lvl_l;
    next_al_oe_n = ccfg.alarm_low_od ? lvl_l : 1'b0;
    lvl_h = ALARM_HIGH_REQ ^ ccfg.alarm_high_pol;
    next_ah_o = ccfg.alarm_high_od ? 1'b0 : lvl_h;
    next_ah_oe_n = ccfg.alarm_high_od ? lvl_h : 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      al_o <= 1'b0;
      al_oe_n <= 1'b0;
      ah_o <= 1'b0;
      ah_oe_n <= 1'b0;
    end else begin
      al_o <= next_al_o;
      al_oe_n <= next_al_oe_n;
      ah_o <= next_ah_o;
      ah_oe_n <= next_ah_oe_n;
    end
  end

  assign ALM_LOW_O = al_o;
  assign ALM_LOW_OE_N = al_oe_n;
  assign ALM_HIGH_O = ah_o;
  assign ALM_HIGH_OE_N = ah_oe_n;

  a_temp_reload: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    start_ok |=> TEMP_CFG == $past(temp_word)) else $error("temp setup not reloaded");
  a_ref_field: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    start_ok ##1 !MEAS_START [*2]
    |-> TEMP_CFG.reference_cap_select == $past(temp_word.reference_cap_select, 2))
    else $error("reference select wrong");
  a_zero_trim: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    $changed(TEMP_CFG.zero_cap_select) |-> $past(start_ok)) else $error("offset select moved");
  a_trim_field: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    start_ok |=> TEMP_CFG.temp_trim == $past(temp_word.temp_trim)) else $error("trim wrong");
  a_conv_len: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    start_ok |=> conv_cnt == conv_len($past(temp_word.resolution)) && TEMP_BUSY)
    else $error("conversion period wrong");
  a_cust_load: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (LEAVE_CMD || load_pend) |=> SLAVE_ADDR == $past(cust_word.slave_address_field))
    else $error("customer word not loaded");
  a_alarm_low: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    ARST_N |=> ALM_LOW_OE_N == ($past(ccfg.alarm_low_od)
    && ($past(ALARM_LOW_REQ) ^ $past(ccfg.alarm_low_pol))))
    else $error("low alarm pin wrong");
  a_alarm_high: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    ARST_N |=> ALM_HIGH_O == (!$past(ccfg.alarm_high_od)
    && ($past(ALARM_HIGH_REQ) ^ $past(ccfg.alarm_high_pol))))
    else $error("high alarm pin wrong");
  a_spi_edge: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    LEAVE_CMD |=> SPI_SAMPLE_FALLING == $past(cust_word.spi_sample_falling)) else $error("edge wrong");
  a_cmd_window: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    ARST_N && load_pend |=> win_cnt == ($past(cust_word.fast_startup) ? WS : WL))
    else $error("window wrong");
  a_corr_latency: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    start_ok |=> !CORR_VALID [*3] ##1 CORR_VALID) else $error("result not in 4 cycles");
  a_region_split: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (state == ST_POLY && !cubic_mode) |-> r1 <= sx(coef[CI_SPLIT]) && r2 >= 0)
    else $error("region split wrong");
  a_temp_delta: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    start_ok |=> dt == sx($past(RAW_TEMP)) - sx($past(coef[CI_TEMP_REF]))) else $error("delta wrong");
endmodule

// ===== tb/scc_host.sv
module scc_host (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // one apb transfer, opens one edge after entry so strobes never clash
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait as long as the slave needs, the bench watchdog bounds it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== tb/tb.sv
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scc_pkg::*;
  logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        meas_start, leave_cmd, alm_lo_req, alm_hi_req, temp_busy, spi_fall;
  logic        ready_od, win_open, alo, alo_oe_n, ahi, ahi_oe_n, corr_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, corr_out, r;
  logic [15:0] raw_cap, raw_temp, prev, nw;
  logic [6:0]  slave_addr;
  logic        e;
  scc_tcfg_s   temp_cfg;
  int          num_errors, samples_checked, cyc;
  int          conv[4] = '{20, 30, 40, 50};

  scc_sensor_config_and_correction #(.CONV_CYC_8_P(20), .CONV_CYC_10_P(30),
    .CONV_CYC_12_P(40), .CONV_CYC_14_P(50), .WIN_CYC_LONG_P(100)
  ) scc_sensor_config_and_correction_i (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MEAS_START(meas_start), .RAW_CAP(raw_cap), .RAW_TEMP(raw_temp), .LEAVE_CMD(leave_cmd),
    .ALARM_LOW_REQ(alm_lo_req), .ALARM_HIGH_REQ(alm_hi_req), .TEMP_CFG(temp_cfg),
    .TEMP_BUSY(temp_busy), .SLAVE_ADDR(slave_addr), .SPI_SAMPLE_FALLING(spi_fall),
    .READY_OPEN_DRAIN(ready_od), .CMD_WINDOW_OPEN(win_open), .ALM_LOW_O(alo),
    .ALM_LOW_OE_N(alo_oe_n), .ALM_HIGH_O(ahi), .ALM_HIGH_OE_N(ahi_oe_n),
    .CORR_OUT(corr_out), .CORR_VALID(corr_valid));

  scc_host scc_host_i (.clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= arst_n ? cyc + 1 : 0;

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rr;
    logic        ee;
    scc_host_i.xfer(1'b1, a, d, rr, ee);
  endtask

  task automatic rd(input logic [11:0] a);
    scc_host_i.xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask

  // start pulse, result pulse stands in the fourth cycle after the taking edge
  task automatic meas(input logic [15:0] c, input logic [15:0] t);
    @(posedge ref_clk);
    meas_start <= 1'b1;
    raw_cap    <= c;
    raw_temp   <= t;
    @(posedge ref_clk);
    meas_start <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(corr_valid, 1'b0)
    @(posedge ref_clk);
    #1;
    `CHK(corr_valid, 1'b1)
  endtask

  task automatic t_reset_values;
    wait (cyc == 3);
    #1;
    `CHK(win_open, 1'b1)
    `CHK(temp_cfg, 16'h8D92)
    `CHK(slave_addr, 7'h28)
    rd(12'h044);
    `CHK(r, 32'h0000_8D92)
    rd(12'h070);
    `CHK(r, 32'h0000_0028)
    rd(12'h0FC);
    `CHK({e, r}, 33'h0_0000_0000 | 33'h1_0000_0000)
    rd(12'h800);
    `CHK({e, r}, 33'h1_0000_0000)
    wait (cyc == 92);
    #1;
    `CHK(win_open, 1'b1)
    wait (cyc == 110);
    #1;
    `CHK(win_open, 1'b0)
  endtask

  task automatic t_temp_reload;
    prev = 16'h8D92;
    for (int k = 0; k < 4; k++) begin
      nw = 16'h8159 | (16'(k) << 10);
      wr(12'h044, {16'h0000, nw});
      #1;
      `CHK(temp_cfg, prev)
      meas(16'd10, 16'd0);
      `CHK(temp_cfg, nw)
      repeat (conv[k] - 4) @(posedge ref_clk);
      #1;
      `CHK(temp_busy, 1'b1)
      @(posedge ref_clk);
      #1;
      `CHK(temp_busy, 1'b0)
      prev = nw;
    end
  endtask

  task automatic t_customer;
    wr(12'h070, 32'h0000_3C95);
    #1;
    `CHK(slave_addr, 7'h28)
    `CHK({alo, alo_oe_n, ahi, ahi_oe_n}, 4'b1010)
    @(posedge ref_clk);
    leave_cmd <= 1'b1;
    @(posedge ref_clk);
    leave_cmd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK({slave_addr, spi_fall, ready_od}, 9'b0010101_1_1)
    `CHK({alo, alo_oe_n, ahi, ahi_oe_n}, 4'b0001)
    @(posedge ref_clk);
    alm_hi_req <= 1'b0;
    alm_lo_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK({alo, alo_oe_n, ahi, ahi_oe_n}, 4'b1000)
  endtask

  task automatic t_correction;
    // coefficients set under the final configuration
    wr(12'h080, 32'h0000_0005);
    wr(12'h084, 32'h0000_4000);
    wr(12'h094, 32'h0000_0010);
    wr(12'h098, 32'h0000_0064);
    wr(12'h09C, 32'h0000_2000);
    wr(12'h0A4, 32'h0000_4000);
    meas(16'd150, 16'h0014);
    `CHK(corr_out, 32'h0000_00D6)
    rd(12'h0B8);
    `CHK(r, 32'h0000_009D)
    meas(16'd50, 16'h0014);
    `CHK(corr_out, 32'h0000_0039)
    wr(12'h0AC, 32'h0000_0001);
    meas(16'd150, 16'h0014);
    `CHK(corr_out, 32'h0000_009D)
    wr(12'h0A8, 32'h0000_4000);
    meas(16'h2000, 16'h0014);
    `CHK(corr_out, 32'h0000_2047)
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200us;
    num_errors++;
    test_done();
  end

  initial begin
    {arst_n, meas_start, leave_cmd} = 3'b000;
    {alm_lo_req, alm_hi_req} = 2'b11;
    raw_cap = 16'h0000;
    raw_temp = 16'h0000;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset_values();
    t_temp_reload();
    t_customer();
    t_correction();
    test_done();
  end
endmodule
